/* File: pwlr_pkg.sv */
/*
 Shared constants and carrier types of the power and range feature block.
 Assumes one clock, clk_sys, and a synchronous active-high reset.
*/
`default_nettype none
package pwlr_pkg;
   // Software register map
   localparam logic [7:0] REG_CFG = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
   localparam int CFG_APST_BIT = 0;
   localparam int CFG_COUNT_LSB = 8;
   localparam logic CFG_APST_RESET = 1'b0;
   localparam logic [4:0] CFG_COUNT_RESET = 5'h04;
   localparam int STAT_HINT_LSB = 5;
   localparam int STAT_RANGES_LSB = 8;
   localparam int STAT_BUSY_BIT = 16;
   // Interrupt events
   localparam int IRQ_W = 3;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERR = 1;
   localparam int IRQ_PWR = 2;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
   // Feature identifiers
   localparam logic [7:0] FID_POWER = 8'h02;
   localparam logic [7:0] FID_RANGE = 8'h03;
   // Command dword 11 fields
   localparam int PS_LSB = 0;
   localparam int PS_W = 5;
   localparam int HINT_LSB = 5;
   localparam int HINT_W = 3;
   localparam int NUM_LSB = 0;
   localparam int NUM_W = 6;
   localparam logic [PS_W-1:0] PS_RESET = 5'h00;
   localparam logic [HINT_W-1:0] HINT_RESET = 3'h0;
   localparam logic [NUM_W-1:0] NUM_RESET = 6'h00;
   // Range table layout
   localparam int TABLE_BYTES = 4096;
   localparam int TABLE_WORDS = TABLE_BYTES / 4;
   localparam int ENTRY_BYTES = 64;
   localparam int ENTRY_WORDS = ENTRY_BYTES / 4;
   localparam int MAX_ENTRIES = 64;
   localparam int MEM_WORDS = 2 * TABLE_WORDS;
   localparam logic [3:0] W_TYPE_ATTR = 4'h0;
   localparam logic [3:0] W_START = 4'h4;
   localparam logic [3:0] W_COUNT = 4'h6;
   localparam logic [3:0] W_GUID = 4'h8;
   // Range types and attribute bits
   localparam logic [7:0] TYPE_RESERVED = 8'h00;
   localparam logic [7:0] TYPE_FILESYSTEM = 8'h01;
   localparam logic [7:0] TYPE_RAID = 8'h02;
   localparam logic [7:0] TYPE_CACHE = 8'h03;
   localparam logic [7:0] TYPE_SWAP = 8'h04;
   localparam logic [7:0] TYPE_VENDOR_MIN = 8'h80;
   localparam int ATTR_OVERWRITE_BIT = 0;
   localparam int ATTR_HIDDEN_BIT = 1;
   // Default table entry
   localparam logic [7:0] DEF_TYPE = TYPE_RESERVED;
   localparam logic [7:0] DEF_ATTR = 8'h01;
   localparam logic [63:0] DEF_NS_LAST = 64'h0000_0000_00ff_ffff;
   // Arbitrary identifier value
   localparam logic [127:0] DEF_GUID =
      128'h0123_4567_89ab_cdef_0f1e_2d3c_4b5a_6978;
   // Completion status codes
   localparam logic [7:0] ST_OK = 8'h00;
   localparam logic [7:0] ST_INVALID_FIELD = 8'h01;
   localparam logic [7:0] ST_OVERLAP = 8'h02;

   typedef struct packed {
      logic set;
      logic [7:0] fid;
      logic [31:0] dw11;
   } pwlr_cmd_t;

   typedef struct packed {
      logic [31:0] dw0;
      logic [7:0] status;
   } pwlr_cpl_t;
endpackage
`default_nettype wire

/* File: pwlr_table_mem.sv */
/*
 Two-bank word memory for the range table, registered read data.
 Assumes one clock and a synchronous active-high reset on the read register.
*/
`default_nettype none
module pwlr_table_mem
   import pwlr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic we,
   input wire logic [10:0] waddr,
   input wire logic [31:0] wdata,
   input wire logic [10:0] raddr,
   output logic [31:0] rdata
);
   logic [31:0] mem [MEM_WORDS];

   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule // pwlr_table_mem
`default_nettype wire

/* File: pwlr_feature_ctl.sv */
/*
 Set and get handling of the power management and range type features.
 Assumes commands, table words and register strobes synchronous to clk_sys;
 the host accepts every read-back word as it is presented.
*/
// Chosen here: the register offsets and the strobed register port.
`default_nettype none
module pwlr_feature_ctl
   import pwlr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic cmd_valid,
   input wire pwlr_cmd_t cmd,
   output logic cmd_ready,
   output logic cpl_valid,
   output pwlr_cpl_t cpl,
   input wire logic din_valid,
   input wire logic [31:0] din_data,
   output logic din_ready,
   output logic dout_valid,
   output logic [31:0] dout_data,
   input wire logic auto_step,
   output logic [PS_W-1:0] power_state,
   output logic [HINT_W-1:0] workload_hint,
   output logic irq
);
   typedef enum logic [2:0] {
      S_INIT, S_IDLE, S_LOAD, S_CHECK, S_DUMP, S_FLUSH
   } pwlr_state_t;

   pwlr_state_t st;
   logic [9:0] wptr;
   logic bank;
   logic cfg_apst;
   logic [PS_W-1:0] cfg_count;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_mask;
   logic [NUM_W-1:0] range_count;
   logic [NUM_W-1:0] load_num;
   logic [31:0] start_lo;
   logic [31:0] cnt_lo;
   logic [63:0] rng_lo [MAX_ENTRIES];
   logic [63:0] rng_hi [MAX_ENTRIES];
   logic [6:0] ci;
   logic [6:0] cj;
   logic [31:0] mem_rdata;
   logic next_cpl_valid;
   pwlr_cpl_t next_cpl;
   logic [PS_W-1:0] next_ps;

   function automatic logic [31:0] default_word(input logic [9:0] a);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (a[9:4] == 6'h00) begin
         case (a[3:0])
            W_TYPE_ATTR: begin
               w[7:0] = DEF_TYPE;
               w[15:8] = DEF_ATTR;
            end
            W_COUNT: w = DEF_NS_LAST[31:0];
            W_COUNT + 4'h1: w = DEF_NS_LAST[63:32];
            W_GUID: w = DEF_GUID[31:0];
            W_GUID + 4'h1: w = DEF_GUID[63:32];
            W_GUID + 4'h2: w = DEF_GUID[95:64];
            W_GUID + 4'h3: w = DEF_GUID[127:96];
            default: w = 32'h0000_0000;
         endcase
      end
      return w;
   endfunction

   // Register decode
   wire hit_cfg = reg_addr == REG_CFG;
   wire hit_status = reg_addr == REG_STATUS;
   wire hit_istat = reg_addr == REG_IRQ_STAT;
   wire hit_imask = reg_addr == REG_IRQ_MASK;
   wire [31:0] cfg_word = {19'h0, cfg_count, 7'h00, cfg_apst};
   wire [31:0] status_word = {15'h0, st != S_IDLE, 2'h0, range_count,
      workload_hint, power_state};
   wire [31:0] rd_mux = hit_cfg ? cfg_word :
      hit_status ? status_word :
      hit_istat ? {29'h0, irq_stat} :
      hit_imask ? {29'h0, irq_mask} : 32'h0000_0000;

   // Command decode
   assign cmd_ready = st == S_IDLE;
   wire cmd_take = cmd_valid & cmd_ready;
   wire is_pwr = cmd.fid == FID_POWER;
   wire is_rng = cmd.fid == FID_RANGE;
   wire [PS_W-1:0] req_ps = cmd.dw11[PS_LSB +: PS_W];
   wire [HINT_W-1:0] req_hint = cmd.dw11[HINT_LSB +: HINT_W];
   wire ps_ok = req_ps <= cfg_count;
   wire pwr_set_ok = cmd_take & is_pwr & cmd.set & ps_ok;
   wire rng_set = cmd_take & is_rng & cmd.set;
   wire rng_get = cmd_take & is_rng & ~cmd.set;

   // Table load decode
   assign din_ready = st == S_LOAD;
   wire din_take = din_valid & din_ready;
   wire [5:0] entry = wptr[9:4];
   wire [3:0] word = wptr[3:0];
   wire unused_entry = entry > load_num;
   wire last_word = wptr == 10'(TABLE_WORDS - 1);

   // Overlap check decode
   wire chk_pass = ci > {1'b0, load_num};
   wire pair_ovl = ~chk_pass & (rng_lo[ci[5:0]] <= rng_hi[cj[5:0]]) &
      (rng_lo[cj[5:0]] <= rng_hi[ci[5:0]]);
   wire chk_end = chk_pass | pair_ovl;
   wire last_pair = cj == ci - 7'h01;

   // Memory ports
   wire mem_we = (st == S_INIT) | din_take;
   wire [10:0] mem_waddr = (st == S_INIT) ? {1'b0, wptr} : {~bank, wptr};
   wire [31:0] mem_wdata = (st == S_INIT) ? default_word(wptr) :
      unused_entry ? 32'h0000_0000 : din_data;
   wire [10:0] mem_raddr = {bank, wptr};

   pwlr_table_mem u_mem (
      .clk_sys(clk_sys),
      .rst(rst),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .raddr(mem_raddr),
      .rdata(mem_rdata)
   );

   // Completion source selection
   always_comb begin
      next_cpl_valid = 1'b0;
      next_cpl = '0;
      if (cmd_take & ~is_rng) begin
         next_cpl_valid = 1'b1;
         if (!is_pwr) begin
            next_cpl.status = ST_INVALID_FIELD;
         end else if (cmd.set) begin
            next_cpl.status = ps_ok ? ST_OK : ST_INVALID_FIELD;
         end else begin
            next_cpl.dw0 = {24'h0, workload_hint,
               power_state};
         end
      end else if (st == S_CHECK && chk_end) begin
         next_cpl_valid = 1'b1;
         next_cpl.status = pair_ovl ? ST_OVERLAP : ST_OK;
      end else if (st == S_FLUSH) begin
         next_cpl_valid = 1'b1;
         next_cpl.dw0 = {26'h0, range_count};
      end
   end

   // Power state: explicit set, then autonomous steps from there
   assign next_ps = pwr_set_ok ? req_ps :
      (auto_step & cfg_apst & (power_state < cfg_count)) ?
      power_state + 5'h01 : power_state;

   wire [IRQ_W-1:0] events;
   assign events[IRQ_DONE] = next_cpl_valid;
   assign events[IRQ_ERR] = next_cpl_valid & (next_cpl.status != ST_OK);
   assign events[IRQ_PWR] = next_ps != power_state;
   wire [IRQ_W-1:0] irq_clr = (reg_wr & hit_istat) ?
      reg_wdata[IRQ_W-1:0] : IRQ_RESET;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         power_state <= PS_RESET;
         workload_hint <= HINT_RESET;
      end else begin
         power_state <= next_ps;
         if (pwr_set_ok) begin
            workload_hint <= req_hint;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cfg_apst <= CFG_APST_RESET;
         cfg_count <= CFG_COUNT_RESET;
         irq_mask <= IRQ_RESET;
         irq_stat <= IRQ_RESET;
         reg_rdata <= 32'h0000_0000;
      end else begin
         if (reg_wr & hit_cfg) begin
            cfg_apst <= reg_wdata[CFG_APST_BIT];
            cfg_count <= reg_wdata[CFG_COUNT_LSB +: PS_W];
         end
         if (reg_wr & hit_imask) begin
            irq_mask <= reg_wdata[IRQ_W-1:0];
         end
         irq_stat <= (irq_stat & ~irq_clr) | events;
         reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end

   assign irq = |(irq_stat & irq_mask);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cpl_valid <= 1'b0;
         cpl <= '0;
         dout_valid <= 1'b0;
      end else begin
         cpl_valid <= next_cpl_valid;
         cpl <= next_cpl;
         dout_valid <= st == S_DUMP;
      end
   end

   assign dout_data = mem_rdata;

   // Entry bounds captured while the table streams in
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         start_lo <= 32'h0000_0000;
         cnt_lo <= 32'h0000_0000;
      end else if (din_take) begin
         if (word == W_START) begin
            start_lo <= din_data;
         end
         if (word == W_COUNT) begin
            cnt_lo <= din_data;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (din_take && word == W_START + 4'h1) begin
         rng_lo[entry] <= {din_data, start_lo};
      end
      if (din_take && word == W_COUNT + 4'h1) begin
         rng_hi[entry] <= rng_lo[entry] + {din_data, cnt_lo};
      end
   end

   // Sequencer
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st <= S_INIT;
         wptr <= 10'h000;
         bank <= 1'b0;
         range_count <= NUM_RESET;
         load_num <= NUM_RESET;
         ci <= 7'h00;
         cj <= 7'h00;
      end else begin
         case (st)
            S_INIT: begin
               wptr <= wptr + 10'h001;
               if (last_word) begin
                  st <= S_IDLE;
               end
            end
            S_IDLE: begin
               if (rng_set) begin
                  load_num <= cmd.dw11[NUM_LSB +: NUM_W];
                  st <= S_LOAD;
               end else if (rng_get) begin
                  st <= S_DUMP;
               end
            end
            S_LOAD: begin
               if (din_take) begin
                  wptr <= wptr + 10'h001;
                  if (last_word) begin
                     ci <= 7'h01;
                     cj <= 7'h00;
                     st <= S_CHECK;
                  end
               end
            end
            S_CHECK: begin
               if (chk_end) begin
                  if (!pair_ovl) begin
                     bank <= ~bank;
                     range_count <= load_num;
                  end
                  st <= S_IDLE;
               end else if (last_pair) begin
                  ci <= ci + 7'h01;
                  cj <= 7'h00;
               end else begin
                  cj <= cj + 7'h01;
               end
            end
            S_DUMP: begin
               wptr <= wptr + 10'h001;
               if (last_word) begin
                  st <= S_FLUSH;
               end
            end
            S_FLUSH: begin
               st <= S_IDLE;
            end
            default: begin
               st <= S_IDLE;
            end
         endcase
      end
   end
endmodule // pwlr_feature_ctl
`default_nettype wire

/* File: pwlr_feature_ctl_asserts.sv */
/*
 Port checker of the power and range feature block.
 Assumes the single clock clk_sys and synchronous active-high rst.
*/
`default_nettype none
module pwlr_feature_ctl_asserts
   import pwlr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic cmd_valid,
   input wire pwlr_cmd_t cmd,
   input wire logic cmd_ready,
   input wire logic cpl_valid,
   input wire pwlr_cpl_t cpl,
   input wire logic dout_valid,
   input wire logic [PS_W-1:0] power_state,
   input wire logic [HINT_W-1:0] workload_hint
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire take = cmd_valid && cmd_ready;
   wire pw_set = take && cmd.set && cmd.fid == FID_POWER;
   wire pw_get = take && !cmd.set && cmd.fid == FID_POWER;
   wire rg_get = take && !cmd.set && cmd.fid == FID_RANGE;
   sequence s_pw_ok;
      pw_set ##1 cpl.status == ST_OK;
   endsequence
   sequence s_dump;
      dout_valid [*8];
   endsequence
   property p_pw_state;
      s_pw_ok |-> power_state == $past(cmd.dw11[4:0]);
   endproperty
   property p_pw_hint;
      s_pw_ok |-> workload_hint == $past(cmd.dw11[7:5]);
   endproperty
   property p_pw_bad;
      pw_set ##1 cpl.status != ST_OK |-> power_state == $past(power_state);
   endproperty
   property p_pw_get;
      pw_get |=> cpl_valid && cpl.dw0 == {24'h0, workload_hint, power_state};
   endproperty
   property p_cpl_idle;
      !cpl_valid |-> cpl == '0;
   endproperty
   property p_rd;
      !$past(reg_rd) |-> reg_rdata == 32'h0;
   endproperty
   property p_dump;
      rg_get |=> !cpl_valid ##1 s_dump;
   endproperty
   property p_busy;
      dout_valid |-> !cmd_ready;
   endproperty
   property p_step;
      $changed(power_state) |->
         power_state == $past(power_state) + 5'h1 || $past(take);
   endproperty
   a_pw_state: assert property (p_pw_state) else $error("bad state");
   a_pw_hint: assert property (p_pw_hint) else $error("bad hint");
   a_pw_bad: assert property (p_pw_bad) else $error("state moved");
   a_pw_get: assert property (p_pw_get) else $error("bad dw0");
   a_cpl_idle: assert property (p_cpl_idle) else $error("cpl not zero");
   a_rd: assert property (p_rd) else $error("rdata not zero");
   a_dump: assert property (p_dump) else $error("bad dump");
   a_busy: assert property (p_busy) else $error("ready in dump");
   a_step: assert property (p_step) else $error("bad step");
endmodule // pwlr_feature_ctl_asserts
bind pwlr_feature_ctl pwlr_feature_ctl_asserts pwlr_feature_ctl_asserts_inst (
   .clk_sys, .rst, .reg_rd, .reg_rdata, .cmd_valid, .cmd, .cmd_ready,
   .cpl_valid, .cpl, .dout_valid, .power_state, .workload_hint);
`default_nettype wire

/* File: pwlr_host_model.sv */
/*
 Host side table source for range set commands.
 Assumes din_ready from the block; words held until taken.
*/
`default_nettype none
module pwlr_host_model
   import pwlr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic host_start,
   input wire logic [5:0] host_num,
   input wire logic host_ovl,
   input wire logic host_stall,
   input wire logic din_ready,
   output logic din_valid,
   output logic [31:0] din_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic active;
   logic gap;
   int k;
   // Entry layout, unused entries zero
   function automatic logic [31:0] word(int i);
      int e;
      e = i / 16;
      if (e > host_num) return 32'h0;
      case (i % 16)
         0: return {16'h0, 8'h03, TYPE_CACHE};
         4: return host_ovl ? 32'h0 : e * 256;
         6: return 32'hff;
         8: return e + 1;
         default: return 32'h0;
      endcase
   endfunction
   assign din_valid = active && !gap;
   assign din_data = din_valid ? word(k) : ~word(k);
   // Exactly 1024 words in one run
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         active <= 1'b0;
         gap <= 1'b0;
         k <= 0;
      end else if (host_start) begin
         active <= 1'b1;
         k <= 0;
      end else begin
         gap <= host_stall && din_valid && din_ready;
         if (din_valid && din_ready) begin
            k <= k + 1;
            if (k == TABLE_WORDS - 1) active <= 1'b0;
         end
      end
   end
endmodule // pwlr_host_model
`default_nettype wire

/* File: power_and_lba_range_features_tb_top.sv */
/*
 Self-checking bench of the power and range feature block.
 Assumes the checker is bound and the host model feeds table words.
*/
`default_nettype none
module power_and_lba_range_features_tb_top;
   import pwlr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, rst, reg_wr, reg_rd, cmd_valid, cmd_ready, cpl_valid;
   logic din_valid, din_ready, dout_valid, auto_step, irq, exp_sel;
   logic host_start, host_ovl, host_stall;
   logic [5:0] host_num;
   logic [7:0] reg_addr, got_st;
   logic [31:0] reg_wdata, reg_rdata, din_data, dout_data, got_dw0;
   logic [PS_W-1:0] power_state;
   logic [HINT_W-1:0] workload_hint;
   pwlr_cmd_t cmd;
   pwlr_cpl_t cpl;
   int num_errors = 0, samples_checked = 0, widx;
   pwlr_feature_ctl pwlr_feature_ctl_inst (.clk_sys, .rst, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmd_valid, .cmd,
      .cmd_ready, .cpl_valid, .cpl, .din_valid, .din_data, .din_ready,
      .dout_valid, .dout_data, .auto_step, .power_state, .workload_hint,
      .irq);
   pwlr_host_model pwlr_host_model_inst (.clk_sys, .rst, .host_start,
      .host_num, .host_ovl, .host_stall, .din_ready, .din_valid, .din_data);
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task tally_and_finish;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] dflt(int k);
      case (k)
         0: return {16'h0, DEF_ATTR, DEF_TYPE};
         6: return DEF_NS_LAST[31:0];
         7: return DEF_NS_LAST[63:32];
         8: return DEF_GUID[31:0];
         9: return DEF_GUID[63:32];
         10: return DEF_GUID[95:64];
         11: return DEF_GUID[127:96];
         default: return 32'h0;
      endcase
   endfunction
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, e);
   endtask
   task run(input logic s, input logic [7:0] f, input logic [31:0] d);
      int n;
      n = 0;
      widx = 0;
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd <= '{s, f, d};
      do @(posedge clk_sys); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      do begin
         @(posedge clk_sys);
         n++;
         if (dout_valid === 1'b1) begin
            check(dout_data, exp_sel ? pwlr_host_model_inst.word(widx)
               : dflt(widx));
            widx++;
         end
      end while (cpl_valid !== 1'b1 && n < 5000);
      check(cpl_valid, 1'b1);
      got_dw0 = cpl.dw0;
      got_st = cpl.status;
   endtask
   task load(input logic [5:0] n, input logic o);
      @(posedge clk_sys);
      host_num <= n;
      host_ovl <= o;
      host_start <= 1'b1;
      @(posedge clk_sys);
      host_start <= 1'b0;
   endtask
   task pulse_step;
      @(posedge clk_sys);
      auto_step <= 1'b1;
      @(posedge clk_sys);
      auto_step <= 1'b0;
      #1;
   endtask
   task t_defaults;
      rd(REG_CFG, {19'h0, CFG_COUNT_RESET, 8'h0});
      rd(REG_STATUS, 32'h0001_0000);
      rd(8'h10, 32'h0);
      while (cmd_ready !== 1'b1) @(posedge clk_sys);
      run(1'b0, FID_RANGE, 32'h3f);
      check(got_dw0, {26'h0, NUM_RESET});
      check(widx, TABLE_WORDS);
      $display("test defaults done");
   endtask
   task t_power;
      pulse_step;
      check(power_state, PS_RESET);
      wr(REG_CFG, 32'h401);
      run(1'b1, FID_POWER, 32'hffff_ffa3);
      check(got_st, ST_OK);
      check(power_state, 5'h3);
      check(workload_hint, 3'h5);
      run(1'b0, FID_POWER, 32'h0);
      check(got_dw0, 32'ha3);
      pulse_step;
      check(power_state, 5'h4);
      pulse_step;
      check(power_state, 5'h4);
      run(1'b1, FID_POWER, 32'h5);
      check(got_st, ST_INVALID_FIELD);
      check(power_state, 5'h4);
      run(1'b0, 8'h7f, 32'h0);
      check(got_st, ST_INVALID_FIELD);
      rd(REG_STATUS, 32'ha4);
      $display("test power done");
   endtask
   task t_irq;
      rd(REG_IRQ_STAT, 32'h7);
      wr(REG_IRQ_MASK, 32'h0);
      check(irq, 1'b0);
      wr(REG_IRQ_MASK, 32'h2);
      check(irq, 1'b1);
      wr(REG_IRQ_STAT, 32'h7);
      check(irq, 1'b0);
      rd(REG_IRQ_STAT, 32'h0);
      $display("test irq done");
   endtask
   task t_range;
      exp_sel = 1'b1;
      host_stall <= 1'b1;
      load(6'h2, 1'b0);
      run(1'b1, FID_RANGE, 32'hffff_ffc2);
      check(got_st, ST_OK);
      check(got_dw0, 32'h0);
      host_stall <= 1'b0;
      load(6'h3, 1'b1);
      run(1'b1, FID_RANGE, 32'h3);
      check(got_st, ST_OVERLAP);
      host_num <= 6'h2;
      host_ovl <= 1'b0;
      run(1'b0, FID_RANGE, 32'h3f);
      check(got_dw0, 32'h2);
      check(widx, TABLE_WORDS);
      rd(REG_STATUS, 32'h2a4);
      $display("test range done");
   endtask
   initial begin
      rst = 1'b1;
      {reg_wr, reg_rd, cmd_valid, auto_step, exp_sel} = '0;
      {host_start, host_ovl, host_stall, host_num} = '0;
      reg_addr = 8'h0;
      reg_wdata = 32'h0;
      cmd = '0;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      t_defaults;
      t_power;
      t_irq;
      t_range;
      tally_and_finish;
   end
   initial begin
      #(25 * 20000);
      num_errors++;
      tally_and_finish;
   end
endmodule // power_and_lba_range_features_tb_top
`default_nettype wire
